// ### rtl/psl_slot_loader.sv
// Secondary-parameter slot loader of one PWM channel, with feedback bytes.
// Assumes a module-cycle strobe from the same clock domain and a simple
// register port driven by a master on this clock.
//
// What this block does
// - Individual mode loads the slot value only when the selector changes.
// - Individual mode toggles the load acknowledge on each accepted selector change.
// - Invalid selector sets load error until error clear; program reloads afterwards.
// - Individual loads show in the record readback and vanish on warm restart.
// - Cyclic mode samples and applies the slot every module cycle per selector.
// - Cyclic mode never touches the load acknowledge.
// - Cyclic out-of-range value sets value error; clears itself when valid.
// - Out-of-range cyclic value ignored; last valid value stays in use.
// - Cyclic mode leaves the record alone; selector change keeps last applied one.
// - After cyclic ends, applied values hold until next load or restart.
// - Period accepted from the selected lower limit up to 10 000 000 us.
// - Individual mode change to selector 0 also toggles the acknowledge.
// - Sequence active only while the software enable has been seen.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module psl_slot_loader
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire logic                module_cycle,
  input  wire logic                warm_restart,
  input  wire logic                stop_to_run,
  input  wire logic                pwm_mode,
  input  wire psl_pkg::psl_range_t range_sel,
  input  wire logic                supply_missing_pin,
  input  wire logic                output_value_error,
  input  wire logic                channel_ready,
  input  wire logic                output_a_state,
  input  wire logic                sequence_running,
  input  wire logic          [3:0] reg_addr,
  input  wire logic         [31:0] reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic              [31:0] reg_rdata,
  output logic              [31:0] period_us,
  output logic                     irq
);
  import psl_pkg::*;

  // Control written by software
  logic [3:0]         param_selector;
  logic               cyclic_mode;
  logic               sw_enable;
  logic [31:0]        slot_value;
  // Sampled state, plus the combinational interrupt events
  logic [3:0]         prev_selector;
  logic [3:0]         applied_selector;
  logic [31:0]        record_period;
  logic               param_load_ack;
  logic               load_error;
  logic               param_value_error;
  logic               sw_enable_seen;
  logic               supply_meta;
  logic               supply_missing;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_mask;
  logic [IRQ_W-1:0]   irq_event;
  // Combinational decode
  logic               slot_in_range;
  logic               selector_changed;
  logic               sel_valid;
  logic               indiv_take;
  logic               indiv_bad;
  logic               indiv_reject;
  logic               cyc_period;
  logic               error_clear;
  logic [7:0]         fb_error;
  logic [7:0]         fb_status;
  logic [7:0]         fb_output;

  psl_range_check u_range
  (
    .value     (slot_value),
    .range_sel (range_sel),
    .in_range  (slot_in_range)
  );

  // Change seen only at module cycle sampling points
  assign selector_changed = module_cycle && (param_selector != prev_selector);
  // Code 0 always valid, code 1 only in PWM, the rest reserved
  assign sel_valid  = (param_selector == SEL_NONE) ||
                      ((param_selector == SEL_PERIOD) && pwm_mode);
  assign indiv_take = !cyclic_mode && selector_changed && sel_valid;
  assign indiv_bad  = !cyclic_mode && selector_changed && !sel_valid;
  assign indiv_reject = indiv_take && (param_selector == SEL_PERIOD) && !slot_in_range;
  // Cyclic period use: code already applied, or picked up fresh from code 0
  assign cyc_period  = cyclic_mode && module_cycle && pwm_mode &&
                       ((applied_selector == SEL_PERIOD) ||
                        ((applied_selector == SEL_NONE) && (param_selector == SEL_PERIOD)));
  assign error_clear = clk_en && reg_write && (reg_addr == CTRL_OFS) && reg_wdata[CTRL_CLR_BIT];

  // Software control register and slot value
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      param_selector <= SEL_RESET;
      cyclic_mode    <= 1'b0;
      sw_enable      <= 1'b0;
      slot_value     <= PERIOD_RESET_US;
    end
    else if (clk_en && reg_write)
    begin
      if (reg_addr == CTRL_OFS)
      begin
        param_selector <= reg_wdata[CTRL_SEL_LSB +: 4];
        cyclic_mode    <= reg_wdata[CTRL_MODE_BIT];
        sw_enable      <= reg_wdata[CTRL_SWEN_BIT];
      end
      if (reg_addr == SLOT_OFS)
      begin
        slot_value <= reg_wdata;
      end
    end
  end

  // Previous-cycle selector sample
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_selector <= SEL_RESET;
    end
    else if (clk_en && module_cycle)
    begin
      prev_selector <= param_selector;
    end
  end

  // Applied period and selector in effect
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      period_us        <= PERIOD_RESET_US;
      applied_selector <= SEL_RESET;
    end
    else if (clk_en)
    begin
      if (stop_to_run)
      begin
        // Restart drops any runtime change
        period_us        <= PERIOD_RESET_US;
        applied_selector <= SEL_RESET;
      end
      else if (indiv_take)
      begin
        applied_selector <= param_selector;
        if ((param_selector == SEL_PERIOD) && slot_in_range)
        begin
          period_us <= slot_value;
        end
      end
      else if (cyc_period)
      begin
        // Selector changes in cyclic mode do not retarget the slot
        applied_selector <= SEL_PERIOD;
        if (slot_in_range)
        begin
          period_us <= slot_value;
        end
      end
    end
  end

  // Parameter record readback copy, individual loads only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      record_period <= PERIOD_RESET_US;
    end
    else if (clk_en)
    begin
      if (warm_restart)
      begin
        record_period <= PERIOD_RESET_US;
      end
      else if (indiv_take && (param_selector == SEL_PERIOD) && slot_in_range)
      begin
        record_period <= slot_value;
      end
    end
  end

  // Acknowledge toggle, individual mode only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      param_load_ack <= 1'b0;
    end
    else if (clk_en && indiv_take && !indiv_reject)
    begin
      // Selector 0 is acknowledged too; cyclic mode never gets here
      param_load_ack <= !param_load_ack;
    end
  end

  // Load error: set by bad selector or out-of-range period load, held until error clear; set wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      load_error <= 1'b0;
    end
    else if (clk_en)
    begin
      if (indiv_bad || indiv_reject)
      begin
        load_error <= 1'b1;
      end
      else if (error_clear)
      begin
        load_error <= 1'b0;
      end
    end
  end

  // Value error tracks the cyclic slot each module cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      param_value_error <= 1'b0;
    end
    else if (clk_en && module_cycle)
    begin
      param_value_error <= cyc_period && !slot_in_range;
    end
  end

  // Software enable level sampled at each module cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sw_enable_seen <= 1'b0;
    end
    else if (clk_en && module_cycle)
    begin
      sw_enable_seen <= sw_enable;
    end
  end

  // Supply pin comes from outside the clock domain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      supply_meta    <= 1'b0;
      supply_missing <= 1'b0;
    end
    else if (clk_en)
    begin
      supply_meta    <= supply_missing_pin;
      supply_missing <= supply_meta;
    end
  end

  // Feedback bytes
  always_comb
  begin
    fb_error                  = 8'h00;
    fb_error[ERR_SUPPLY_BIT]  = supply_missing;
    fb_error[ERR_LOAD_BIT]    = load_error;
    fb_error[ERR_OUTVAL_BIT]  = output_value_error;
    fb_error[ERR_PARAM_BIT]   = param_value_error;
    fb_status                 = 8'h00;
    fb_status[STS_ACK_BIT]    = param_load_ack;
    fb_status[CHANNEL_READY_BIT]  = channel_ready;
    fb_status[STS_SWEN_BIT]   = sw_enable_seen;
    fb_output                 = 8'h00;
    fb_output[OUT_ACTIVE_BIT] = sequence_running && sw_enable_seen;
    fb_output[OUT_STATE_BIT]  = output_a_state;
  end

  // Interrupt events: ack toggle, bad selector, out-of-range cyclic value
  assign irq_event[IRQ_ACK_BIT]   = indiv_take && !indiv_reject;
  assign irq_event[IRQ_LDERR_BIT] = indiv_bad;
  assign irq_event[IRQ_PVERR_BIT] = cyc_period && !slot_in_range;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
    end
    else if (clk_en)
    begin
      if (reg_write && (reg_addr == IRQ_MASK_OFS))
      begin
        irq_mask <= reg_wdata[IRQ_W-1:0];
      end
      irq_status <= (irq_status & ~((reg_write && (reg_addr == IRQ_STATUS_OFS)) ?
                                    reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_event;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read data one cycle after the strobe, zero elsewhere and for unmapped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_read)
      begin
        case (reg_addr)
          {2'b00, FB_ERROR_OFS}:  reg_rdata <= {24'h00_0000, fb_error};
          {2'b00, FB_STATUS_OFS}: reg_rdata <= {24'h00_0000, fb_status};
          {2'b00, FB_OUTPUT_OFS}: reg_rdata <= {24'h00_0000, fb_output};
          CTRL_OFS:               reg_rdata <= {26'h000_0000, sw_enable, cyclic_mode,
                                                 param_selector};
          IRQ_STATUS_OFS:         reg_rdata <= {29'h0000_0000, irq_status};
          IRQ_MASK_OFS:           reg_rdata <= {29'h0000_0000, irq_mask};
          RECORD_OFS:             reg_rdata <= record_period;
          SLOT_OFS:               reg_rdata <= slot_value;
          default:                reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : psl_slot_loader

// ### rtl/psl_pkg.sv
// Constants shared by the period-slot loader: feedback byte map, field positions,
// selector codes, limits and reset values.
// Assumes a 10 MHz clock and one module cycle marked by a one-cycle strobe.
package psl_pkg;

  // Feedback register offsets (byte index)
  localparam logic [1:0] FB_ERROR_OFS  = 2'h0;
  localparam logic [1:0] FB_STATUS_OFS = 2'h1;
  localparam logic [1:0] FB_OUTPUT_OFS = 2'h2;
  localparam logic [1:0] FB_RSVD_OFS   = 2'h3;

  // Error byte bit positions
  localparam int ERR_SUPPLY_BIT  = 0;
  localparam int ERR_LOAD_BIT    = 2;
  localparam int ERR_OUTVAL_BIT  = 6;
  localparam int ERR_PARAM_BIT   = 7;
  // Status byte bit positions
  localparam int STS_ACK_BIT     = 2;
  localparam int CHANNEL_READY_BIT   = 4;
  localparam int STS_SWEN_BIT    = 5;
  // Output byte bit positions
  localparam int OUT_ACTIVE_BIT  = 0;
  localparam int OUT_STATE_BIT   = 1;

  // Own registers: control, interrupt status, interrupt mask, period readback, slot value
  localparam logic [3:0] CTRL_OFS       = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h5;
  localparam logic [3:0] IRQ_MASK_OFS   = 4'h6;
  localparam logic [3:0] RECORD_OFS     = 4'h7;
  localparam logic [3:0] SLOT_OFS       = 4'h8;
  // Control register fields
  localparam int CTRL_SEL_LSB    = 0;
  localparam int CTRL_MODE_BIT   = 4;
  localparam int CTRL_SWEN_BIT   = 5;
  localparam int CTRL_CLR_BIT    = 6;

  // Interrupt status bits
  localparam int IRQ_ACK_BIT     = 0;
  localparam int IRQ_LDERR_BIT   = 1;
  localparam int IRQ_PVERR_BIT   = 2;
  localparam int IRQ_W           = 3;

  // Selector codes
  localparam logic [3:0] SEL_NONE   = 4'h0;
  localparam logic [3:0] SEL_PERIOD = 4'h1;

  // Period limits in microseconds
  localparam logic [31:0] PERIOD_MIN_FAST_US = 32'h0000_000A;  // 10 us
  localparam logic [31:0] PERIOD_MIN_STD_US  = 32'h0000_0064;  // 100 us
  localparam logic [31:0] PERIOD_MIN_SLOW_US = 32'h0000_2710;  // 10 000 us
  localparam logic [31:0] PERIOD_MAX_US      = 32'h0098_9680;  // 10 000 000 us

  // Reset / restart values
  localparam logic [31:0] PERIOD_RESET_US = 32'h0000_03E8;     // Default period, plain value
  localparam logic [3:0]  SEL_RESET       = 4'h0;

  // Range selection for lower period limit
  typedef enum logic [1:0]
  {
    PSL_RANGE_FAST = 2'b00,
    PSL_RANGE_STD  = 2'b01,
    PSL_RANGE_SLOW = 2'b11
  } psl_range_t;

endpackage : psl_pkg

// ### rtl/psl_range_check.sv
// Range checker for a period value against the selected lower limit.
// Assumes the value and range select are stable in the cycle they are used.
`timescale 1ns/10ps
module psl_range_check
(
  input  wire logic              [31:0] value,
  input  wire psl_pkg::psl_range_t      range_sel,
  output logic                          in_range
);
  import psl_pkg::*;

  logic [31:0] lower_limit;

  // Lower bound depends on output and speed mode
  always_comb
  begin
    case (range_sel)
      PSL_RANGE_FAST: lower_limit = PERIOD_MIN_FAST_US;
      PSL_RANGE_STD:  lower_limit = PERIOD_MIN_STD_US;
      PSL_RANGE_SLOW: lower_limit = PERIOD_MIN_SLOW_US;
      default:        lower_limit = PERIOD_MIN_SLOW_US;
    endcase
  end

  // Both limits inclusive
  assign in_range = (value >= lower_limit) && (value <= PERIOD_MAX_US);

endmodule : psl_range_check

// ### dv/psl_slot_loader_checker.sv
// Checker for the slot loader: read data timing and applied period.
// Assumes one clock domain; it sees only the top ports and is bound below.
`timescale 1ns/10ps
module psl_slot_loader_checker
  import psl_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                clk_en,
  input wire logic                module_cycle,
  input wire logic                stop_to_run,
  input wire logic                pwm_mode,
  input wire psl_pkg::psl_range_t range_sel,
  input wire logic                sequence_running,
  input wire logic          [3:0] reg_addr,
  input wire logic                reg_read,
  input wire logic         [31:0] reg_rdata,
  input wire logic         [31:0] period_us
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Read data stands only in the cycle after a read
  AST_RDATA_IDLE: assert property (
    (clk_en && !reg_read) |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  // Applied period never leaves the widest legal range
  AST_PERIOD_BOUNDS: assert property (
    period_us >= PERIOD_MIN_FAST_US && period_us <= PERIOD_MAX_US)
    else $error("applied period out of range");
  AST_PERIOD_SLOW_MIN: assert property (
    (clk_en && module_cycle && !stop_to_run && range_sel == PSL_RANGE_SLOW)
    |=> ($stable(period_us) || period_us >= PERIOD_MIN_SLOW_US))
    else $error("period below slow limit applied");
  // Period moves only at a module cycle or a restart
  AST_PERIOD_HOLD: assert property (
    (clk_en && !module_cycle && !stop_to_run) |=> $stable(period_us))
    else $error("period changed between module cycles");
  AST_PERIOD_NEEDS_PWM: assert property (
    (clk_en && !pwm_mode && !stop_to_run) |=> $stable(period_us))
    else $error("period changed outside pwm mode");
  AST_STOP_RUN: assert property (
    (clk_en && stop_to_run && !module_cycle) |=> period_us == PERIOD_RESET_US)
    else $error("restart did not restore period");
  AST_RESET_PERIOD: assert property ($rose(rst_n) |-> period_us == PERIOD_RESET_US)
    else $error("period wrong after reset");
  AST_SEQ_IDLE: assert property ((clk_en && reg_read && reg_addr == {2'b00, FB_OUTPUT_OFS} &&
    !sequence_running) |=> !reg_rdata[OUT_ACTIVE_BIT])
    else $error("sequence active without running sequence");
endmodule : psl_slot_loader_checker

bind psl_slot_loader psl_slot_loader_checker psl_slot_loader_checker_inst (.clk, .rst_n, .clk_en,
  .module_cycle, .stop_to_run, .pwm_mode, .range_sel, .sequence_running, .reg_addr, .reg_read,
  .reg_rdata, .period_us);

// ### dv/tb.sv
// Self-checking bench for the slot loader, one task per scenario.
// Assumes the checker is bound to the design; drives every port itself.
`timescale 1ns/10ps
module tb;
  import psl_pkg::*;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic        clk, rst_n, clk_en, module_cycle, warm_restart, stop_to_run;
  logic        pwm_mode, supply_missing_pin, output_value_error, channel_ready;
  logic        output_a_state, sequence_running, reg_write, reg_read, irq;
  psl_range_t  range_sel;
  logic  [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, period_us, rv;
  int          n_errors, num_checks, cycles;

  psl_slot_loader psl_slot_loader_inst (.clk, .rst_n, .clk_en, .module_cycle, .warm_restart,
    .stop_to_run, .pwm_mode, .range_sel, .supply_missing_pin, .output_value_error,
    .channel_ready, .output_a_state, .sequence_running, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .period_us, .irq);

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus cycles: strobe for one edge, then settle past the edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  task automatic mcyc;
    @(posedge clk);
    module_cycle <= 1'b1;
    @(posedge clk);
    module_cycle <= 1'b0;
    #1;
  endtask : mcyc

  task automatic t_reset;
    chk("period", PERIOD_RESET_US, period_us);
    chk("irq", ZERO, {31'h0, irq});
    rd(CTRL_OFS);
    chk("ctrl", ZERO, rv);
    rd(4'h3);
    chk("reserved", ZERO, rv);
    rd(4'hF);
    chk("unmapped", ZERO, rv);
    wr(RECORD_OFS, 32'h0000_1234);
    rd(RECORD_OFS);
    chk("record read only", PERIOD_RESET_US, rv);
    $display("test reset done");
  endtask : t_reset

  task automatic t_indiv;
    wr(SLOT_OFS, 32'h0000_1388);
    wr(CTRL_OFS, 32'h0000_0001);
    chk("period before cycle", PERIOD_RESET_US, period_us);
    mcyc();
    chk("period loaded", 32'h0000_1388, period_us);
    rd(4'h1);
    chk("ack", 32'h0000_0004, rv);
    rd(RECORD_OFS);
    chk("record", 32'h0000_1388, rv);
    wr(SLOT_OFS, 32'h0000_1B58);
    mcyc();
    chk("period same selector", 32'h0000_1388, period_us);
    rd(4'h1);
    chk("ack same selector", 32'h0000_0004, rv);
    wr(CTRL_OFS, ZERO);
    mcyc();
    rd(4'h1);
    chk("ack selector 0", ZERO, rv);
    chk("period selector 0", 32'h0000_1388, period_us);
    $display("test individual done");
  endtask : t_indiv

  task automatic t_error;
    wr(CTRL_OFS, 32'h0000_0002);
    mcyc();
    rd(4'h0);
    chk("load error", 32'h0000_0004, rv);
    rd(4'h1);
    chk("ack bad selector", ZERO, rv);
    chk("irq masked", ZERO, {31'h0, irq});
    wr(IRQ_MASK_OFS, 32'h0000_0002);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    wr(CTRL_OFS, 32'h0000_0042);
    rd(4'h0);
    chk("load error cleared", ZERO, rv);
    wr(IRQ_STATUS_OFS, 32'h0000_0007);
    chk("irq cleared", ZERO, {31'h0, irq});
    wr(CTRL_OFS, ZERO);
    mcyc();
    rd(4'h1);
    chk("ack reload", 32'h0000_0004, rv);
    $display("test error done");
  endtask : t_error

  task automatic t_cyclic;
    wr(SLOT_OFS, 32'h0000_07D0);
    wr(CTRL_OFS, 32'h0000_0011);
    mcyc();
    chk("cyclic period", 32'h0000_07D0, period_us);
    wr(SLOT_OFS, 32'h0098_9681);
    mcyc();
    chk("cyclic keeps valid", 32'h0000_07D0, period_us);
    rd(4'h0);
    chk("value error", 32'h0000_0080, rv);
    wr(SLOT_OFS, 32'h0000_000A);
    mcyc();
    chk("cyclic minimum", 32'h0000_000A, period_us);
    rd(4'h0);
    chk("value error gone", ZERO, rv);
    rd(4'h1);
    chk("ack untouched", 32'h0000_0004, rv);
    rd(RECORD_OFS);
    chk("record untouched", 32'h0000_1388, rv);
    wr(CTRL_OFS, 32'h0000_0012);
    wr(SLOT_OFS, 32'h0000_0BB8);
    mcyc();
    chk("selector kept", 32'h0000_0BB8, period_us);
    wr(CTRL_OFS, ZERO);
    mcyc();
    wr(SLOT_OFS, 32'h0000_0FA0);
    mcyc();
    chk("after cyclic", 32'h0000_0BB8, period_us);
    @(posedge clk);
    stop_to_run <= 1'b1;
    @(posedge clk);
    stop_to_run <= 1'b0;
    #1 chk("stop to run", PERIOD_RESET_US, period_us);
    $display("test cyclic done");
  endtask : t_cyclic

  task automatic t_restart;
    @(posedge clk);
    warm_restart <= 1'b1;
    @(posedge clk);
    warm_restart <= 1'b0;
    rd(RECORD_OFS);
    chk("record after restart", PERIOD_RESET_US, rv);
    range_sel <= PSL_RANGE_SLOW;
    wr(SLOT_OFS, 32'h0000_1388);
    wr(CTRL_OFS, 32'h0000_0001);
    mcyc();
    chk("below slow limit", PERIOD_RESET_US, period_us);
    rd(4'h0);
    chk("limit error", 32'h0000_0004, rv);
    rd(4'h1);
    chk("ack on reject", ZERO, rv);
    wr(CTRL_OFS, 32'h0000_0040);
    mcyc();
    range_sel <= PSL_RANGE_FAST;
    pwm_mode <= 1'b0;
    wr(CTRL_OFS, 32'h0000_0001);
    mcyc();
    chk("not pwm", PERIOD_RESET_US, period_us);
    rd(4'h0);
    chk("not pwm error", 32'h0000_0004, rv);
    wr(CTRL_OFS, 32'h0000_0040);
    pwm_mode <= 1'b1;
    $display("test restart done");
  endtask : t_restart

  task automatic t_status;
    sequence_running   <= 1'b1;
    channel_ready      <= 1'b1;
    output_a_state     <= 1'b1;
    output_value_error <= 1'b1;
    supply_missing_pin <= 1'b1;
    rd(4'h2);
    chk("sequence without enable", 32'h0000_0002, rv);
    wr(CTRL_OFS, 32'h0000_0020);
    mcyc();
    rd(4'h1);
    chk("enable seen and ready", 32'h0000_0030, rv & 32'h0000_0030);
    rd(4'h2);
    chk("sequence active", 32'h0000_0003, rv);
    rd(4'h0);
    chk("supply and output errors", 32'h0000_0041, rv);
    sequence_running <= 1'b0;
    rd(4'h2);
    chk("sequence stopped", 32'h0000_0002, rv);
    $display("test status done");
  endtask : t_status

  // Sticky interrupt bits, and clock enable freezing writes
  task automatic t_irq;
    rd(IRQ_STATUS_OFS);
    chk("irq status", 32'h0000_0007, rv);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(IRQ_STATUS_OFS, 32'h0000_0007);
    wr(SLOT_OFS, 32'h0000_1F40);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(IRQ_STATUS_OFS);
    chk("irq status frozen", 32'h0000_0007, rv);
    rd(SLOT_OFS);
    chk("slot frozen", 32'h0000_1388, rv);
    wr(IRQ_STATUS_OFS, 32'h0000_0007);
    rd(IRQ_STATUS_OFS);
    chk("irq status cleared", ZERO, rv);
    $display("test irq done");
  endtask : t_irq

  // Reset for eight cycles, then the scenarios in turn
  initial
  begin
    {clk, rst_n, module_cycle, warm_restart, stop_to_run, reg_write, reg_read} = '0;
    {supply_missing_pin, output_value_error, channel_ready, output_a_state} = '0;
    {sequence_running, n_errors, num_checks, cycles} = '0;
    clk_en    = 1'b1;
    pwm_mode  = 1'b1;
    range_sel = PSL_RANGE_FAST;
    reg_addr  = 4'h0;
    reg_wdata = ZERO;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_indiv();
    t_error();
    t_cyclic();
    t_restart();
    t_status();
    t_irq();
    give_verdict();
  end
endmodule : tb
